// ### include/lrc_pkg.sv
// Constants and carrier types for the LCD driver reset control block.
// Assumes a single core clock; no other file depends on outside headers.
package lrc_pkg;

	// ------------------------------------------------------------
	// Register map (AXI4-Lite byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_TIMING = 8'h0C;
	localparam logic [7:0] ADDR_IDLE = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Command register bits
	localparam int CMD_SOFT_RESET = 0;
	localparam int CMD_SLEEP_OUT = 1;
	localparam int CMD_DISPLAY_ON = 2;
	localparam int CMD_GRAD_INV = 3;
	localparam int CMD_PARTIAL_ON = 4;
	localparam int CMD_IDLE_ON = 5;
	localparam int CMD_TEAR_ON = 6;
	localparam int CMD_EXT_SYNC = 7;

	// ------------------------------------------------------------
	// Default values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] DEF_MEM_ACCESS = 8'h00;
	localparam logic [7:0] DEF_EXT_PORT = 8'h00;
	localparam logic [7:0] DEF_EXT_SYNC_OFS = 8'h00;
	localparam logic [7:0] DEF_BACK_PORCH = 8'h05;
	localparam logic [8:0] DEF_LINES = 9'h0F0;
	localparam logic [7:0] DEF_FRONT_PORCH = 8'h04;
	localparam logic [7:0] DEF_LINE_CLKS = 8'h41;
	localparam logic [7:0] DEF_DRIVE = 8'h0A;
	localparam logic [7:0] DEF_IDLE_DIV = 8'h01;
	localparam logic [7:0] DEF_IDLE_VFP_ADD = 8'h08;

	// Length of the initialize and auto display-off sequences, in lines
	localparam logic [3:0] INIT_SEQ_LINES = 4'h2;
	localparam logic [3:0] OFF_SEQ_LINES = 4'h4;

	typedef enum {
		LRC_RUN,
		LRC_WAIT_SYNC,
		LRC_INIT_SEQ,
		LRC_OFF_SEQ,
		LRC_HALT
	} lrc_state_t;

	// Command state restored by resets
	typedef struct packed {
		logic sleep;
		logic display_on;
		logic grad_inv;
		logic partial;
		logic idle;
		logic tear_on;
		logic ext_sync;
		logic [7:0] mem_access;
		logic [7:0] ext_port;
		logic [7:0] ext_sync_ofs;
		logic [7:0] back_porch;
		logic [8:0] lines;
		logic [7:0] front_porch;
		logic [7:0] line_clks;
		logic [7:0] drive;
		logic [7:0] idle_div;
		logic [7:0] idle_vfp_add;
	} lrc_cmd_t;

	localparam lrc_cmd_t CMD_DEFAULT = '{
		sleep: 1'b1, display_on: 1'b0, grad_inv: 1'b0, partial: 1'b0,
		idle: 1'b0, tear_on: 1'b0, ext_sync: 1'b0,
		mem_access: DEF_MEM_ACCESS, ext_port: DEF_EXT_PORT,
		ext_sync_ofs: DEF_EXT_SYNC_OFS, back_porch: DEF_BACK_PORCH,
		lines: DEF_LINES, front_porch: DEF_FRONT_PORCH,
		line_clks: DEF_LINE_CLKS, drive: DEF_DRIVE,
		idle_div: DEF_IDLE_DIV, idle_vfp_add: DEF_IDLE_VFP_ADD};

endpackage

// ### core/lrc_reset_ctl.sv
// Reset control for the LCD driver: hardware and soft reset paths,
// command defaults, power-off flag, horizontal sync, AXI4-Lite registers.
// Assumes CORE_CLK free running and select pins static between resets.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.

module lrc_reset_ctl
	import lrc_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic HARD_RESET_N_PIN,
	input wire logic INIT_SELECT_PIN,
	input wire logic RESET_SEQUENCE_SELECT_PIN,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic POWER_OFF_FLAG_OUT,
	output logic LINE_SYNC,
	output logic HALTED
);

	// ------------------------------------------------------------
	// Hard reset pin release synchronizer
	// ------------------------------------------------------------
	logic hr_meta;
	logic hr_sync;
	logic hard_rst;

	// Assert at once, release only on a clock edge so state leaves together
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			hr_meta <= 1'b0;
			hr_sync <= 1'b0;
		end
		else
		begin
			hr_meta <= HARD_RESET_N_PIN;
			hr_sync <= hr_meta;
		end
	end

	// Pin low acts combinationally on the reset of all state except the synchronizer
	assign hard_rst = RST | ~HARD_RESET_N_PIN | ~hr_sync;

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	lrc_cmd_t cmd;
	lrc_state_t state;
	logic [7:0] hclk_cnt;
	logic [3:0] seq_cnt;
	logic soft_req;
	logic init_sel;
	logic seq_sel;
	logic wr_aw_done;
	logic wr_w_done;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic wr_fire;
	logic [31:0] rd_word;

	function automatic logic [7:0] merge_byte(input logic [7:0] old,
		input logic [7:0] nw, input logic en);
		merge_byte = en ? nw : old;
	endfunction

	// Soft reset values: special commands (timing/port set-up) are
	// kept when init select is high; only the mode flags reinitialize.
	function automatic lrc_cmd_t soft_defaults(input lrc_cmd_t cur,
		input logic init);
		lrc_cmd_t r;
		r = CMD_DEFAULT;
		if (init)
		begin
			r = cur;
			r.sleep = CMD_DEFAULT.sleep;
			r.display_on = CMD_DEFAULT.display_on;
			r.grad_inv = CMD_DEFAULT.grad_inv;
			r.ext_sync = CMD_DEFAULT.ext_sync;
			r.partial = CMD_DEFAULT.partial;
			r.idle = CMD_DEFAULT.idle;
			r.tear_on = CMD_DEFAULT.tear_on;
		end
		soft_defaults = r;
	endfunction

	// ------------------------------------------------------------
	// Internal horizontal sync
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge hard_rst)
	begin
		if (hard_rst)
			hclk_cnt <= 8'h00;
		else if (hclk_cnt >= cmd.line_clks - 8'h01)
			hclk_cnt <= 8'h00;
		else
			hclk_cnt <= hclk_cnt + 8'h01;
	end

	assign LINE_SYNC = (hclk_cnt == 8'h00);

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign AWREADY = ~wr_aw_done & ~BVALID;
	assign WREADY = ~wr_w_done & ~BVALID;
	assign wr_fire = wr_aw_done & wr_w_done & ~BVALID;

	always_ff @(posedge CORE_CLK or posedge hard_rst)
	begin
		if (hard_rst)
		begin
			wr_aw_done <= 1'b0;
			wr_w_done <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				wr_aw_done <= 1'b1;
				wr_addr <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				wr_w_done <= 1'b1;
				wr_data <= {merge_byte(wr_data[31:24], WDATA[31:24], WSTRB[3]),
					merge_byte(wr_data[23:16], WDATA[23:16], WSTRB[2]),
					merge_byte(wr_data[15:8], WDATA[15:8], WSTRB[1]),
					merge_byte(wr_data[7:0], WDATA[7:0], WSTRB[0])};
			end
			if (wr_fire)
			begin
				wr_aw_done <= 1'b0;
				wr_w_done <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= (wr_addr == ADDR_STATUS) ? RESP_SLVERR : RESP_OKAY;
			end
			else if (BVALID && BREADY)
				BVALID <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Command state and reset sequencing
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge hard_rst)
	begin
		if (hard_rst)
			cmd <= CMD_DEFAULT;
		else if (state == LRC_HALT && seq_cnt == 4'h0)
			cmd <= soft_defaults(cmd, init_sel);
		else if (state == LRC_RUN && wr_fire)
		begin
			case (wr_addr)
				ADDR_CMD:
				begin
					cmd.sleep <= ~wr_data[CMD_SLEEP_OUT];
					cmd.display_on <= wr_data[CMD_DISPLAY_ON];
					cmd.grad_inv <= wr_data[CMD_GRAD_INV];
					cmd.partial <= wr_data[CMD_PARTIAL_ON];
					cmd.idle <= wr_data[CMD_IDLE_ON];
					cmd.tear_on <= wr_data[CMD_TEAR_ON];
					cmd.ext_sync <= wr_data[CMD_EXT_SYNC];
				end
				ADDR_MODE:
				begin
					cmd.mem_access <= wr_data[7:0];
					cmd.ext_port <= wr_data[15:8];
					cmd.ext_sync_ofs <= wr_data[23:16];
					cmd.drive <= wr_data[31:24];
				end
				ADDR_TIMING:
				begin
					cmd.back_porch <= wr_data[7:0];
					cmd.front_porch <= wr_data[15:8];
					cmd.line_clks <= wr_data[23:16];
					cmd.lines[7:0] <= wr_data[31:24];
				end
				ADDR_IDLE:
				begin
					cmd.idle_div <= wr_data[7:0];
					cmd.idle_vfp_add <= wr_data[15:8];
					cmd.lines[8] <= wr_data[16];
				end
				default:
					cmd <= cmd;
			endcase
		end
	end
	// Video memory lives elsewhere; no reset path reaches it.

	assign soft_req = wr_fire && wr_addr == ADDR_CMD &&
		wr_data[CMD_SOFT_RESET];

	always_ff @(posedge CORE_CLK or posedge hard_rst)
	begin
		if (hard_rst)
		begin
			state <= LRC_RUN;
			seq_cnt <= 4'h0;
			init_sel <= 1'b0;
			seq_sel <= 1'b0;
			POWER_OFF_FLAG_OUT <= 1'b0;
		end
		else
		begin
			case (state)
				LRC_RUN:
					if (soft_req)
					begin
						init_sel <= INIT_SELECT_PIN;
						seq_sel <= RESET_SEQUENCE_SELECT_PIN;
						if (cmd.display_on)
							state <= LRC_WAIT_SYNC;
						else
						begin
							state <= LRC_HALT;
							seq_cnt <= 4'h0;
							POWER_OFF_FLAG_OUT <= 1'b0;
						end
					end
				LRC_WAIT_SYNC:
					if (LINE_SYNC)
					begin
						POWER_OFF_FLAG_OUT <= 1'b1;
						if (init_sel && seq_sel)
						begin
							state <= LRC_OFF_SEQ;
							seq_cnt <= OFF_SEQ_LINES;
						end
						else if (init_sel)
						begin
							state <= LRC_INIT_SEQ;
							seq_cnt <= INIT_SEQ_LINES;
						end
						else
						begin
							state <= LRC_HALT;
							seq_cnt <= 4'h0;
						end
					end
				LRC_INIT_SEQ, LRC_OFF_SEQ:
					if (LINE_SYNC)
					begin
						if (seq_cnt == 4'h1)
							state <= LRC_HALT;
						seq_cnt <= seq_cnt - 4'h1;
					end
				LRC_HALT:
					// One cycle applies defaults, then normal service resumes
					state <= LRC_RUN;
				default:
					state <= LRC_RUN;
			endcase
		end
	end

	assign HALTED = (state != LRC_RUN);

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_comb
	begin
		case (ARADDR)
			ADDR_CMD:
				rd_word = {24'h00_0000, cmd.ext_sync, cmd.tear_on, cmd.idle,
					cmd.partial, cmd.grad_inv, cmd.display_on, ~cmd.sleep,
					1'b0};
			ADDR_STATUS:
				rd_word = {22'h00_0000, hclk_cnt, HALTED, POWER_OFF_FLAG_OUT};
			ADDR_MODE:
				rd_word = {cmd.drive, cmd.ext_sync_ofs, cmd.ext_port,
					cmd.mem_access};
			ADDR_TIMING:
				rd_word = {cmd.lines[7:0], cmd.line_clks, cmd.front_porch,
					cmd.back_porch};
			ADDR_IDLE:
				rd_word = {15'h0000, cmd.lines[8], cmd.idle_vfp_add,
					cmd.idle_div};
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	assign ARREADY = ~RVALID;

	always_ff @(posedge CORE_CLK or posedge hard_rst)
	begin
		if (hard_rst)
		begin
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= RESP_OKAY;
		end
		else if (ARVALID && ARREADY)
		begin
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= (ARADDR > ADDR_IDLE || ARADDR[1:0] != 2'h0) ?
				RESP_SLVERR : RESP_OKAY;
		end
		else if (RREADY)
			RVALID <= 1'b0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_pin_low_halt: assert property (@(posedge CORE_CLK)
		!HARD_RESET_N_PIN |=> !POWER_OFF_FLAG_OUT && state == LRC_RUN)
		else $error("state moved while reset pin low");

	a_soft_off_flag: assert property (@(posedge CORE_CLK)
		disable iff (hard_rst) state == LRC_RUN && soft_req &&
		!cmd.display_on |=> state == LRC_HALT && !POWER_OFF_FLAG_OUT)
		else $error("soft reset with display off mishandled");

	a_soft_on_wait: assert property (@(posedge CORE_CLK)
		disable iff (hard_rst) state == LRC_WAIT_SYNC && LINE_SYNC
		|=> POWER_OFF_FLAG_OUT)
		else $error("power-off flag not raised at line sync");

	a_off_seq_len: assert property (@(posedge CORE_CLK)
		disable iff (hard_rst) $rose(state == LRC_OFF_SEQ)
		|-> ##[260:300] state == LRC_HALT)
		else $error("display-off sequence wrong length");

	a_stop_direct: assert property (@(posedge CORE_CLK)
		disable iff (hard_rst) state == LRC_WAIT_SYNC && LINE_SYNC &&
		!init_sel |=> state == LRC_HALT)
		else $error("plain soft reset did not stop");

	a_soft_defaults: assert property (@(posedge CORE_CLK)
		disable iff (hard_rst) state == LRC_HALT && !init_sel
		|=> cmd == CMD_DEFAULT)
		else $error("soft reset left command state");

	a_line_period: assert property (@(posedge CORE_CLK)
		disable iff (hard_rst) LINE_SYNC && cmd.line_clks == DEF_LINE_CLKS
		&& $stable(cmd.line_clks) |-> ##65 LINE_SYNC)
		else $error("line period not 65 clocks");

	a_hard_default: assert property (@(posedge CORE_CLK)
		$fell(hard_rst) |-> cmd == CMD_DEFAULT && cmd.lines == DEF_LINES)
		else $error("defaults missing after hard reset");

	a_release_sync: assert property (@(posedge CORE_CLK)
		disable iff (RST) $rose(HARD_RESET_N_PIN) |=> hard_rst)
		else $error("hard reset released without synchronizer delay");

endmodule // lrc_reset_ctl

// ### sim/lrc_host_model.sv
// Host processor model: AXI4-Lite master, owner of the hard reset pin.
// Assumes the bench calls its tasks one at a time from one process.
module lrc_host_model
	import lrc_pkg::*;
(
	input wire logic clk,
	output logic hard_reset_n,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Power-up
	// ------------------------------------------------------------
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		hard_reset_n = 1'b0;
		repeat (8) @(posedge clk);
		hard_reset_n <= 1'b1;
	end

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		r = bresp;
		bready <= 1'b0;
		// Released lines flip so stale values cannot pass for new ones
		awaddr <= ~a;
		wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		araddr <= ~a;
	endtask

	task automatic pin(input logic v);
		@(posedge clk);
		hard_reset_n <= v;
	endtask

	// Covers sync wait plus the longest sequence; no request meanwhile
	task automatic settle();
		repeat (800) @(posedge clk);
	endtask

endmodule // lrc_host_model

// ### sim/tb_lrc_reset_ctl.sv
// Self-checking bench for the reset control block.
// Assumes the host model as the only bus master and pin owner.
module tb_lrc_reset_ctl import lrc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst, init_sel, seq_sel, hard_reset_n, halted, flag, line_sync;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int miscompares = 0;
	int num_checks = 0;
	int halt_cnt = 0;

	lrc_reset_ctl uut (
		.CORE_CLK(clk), .RST(rst), .HARD_RESET_N_PIN(hard_reset_n),
		.INIT_SELECT_PIN(init_sel), .RESET_SEQUENCE_SELECT_PIN(seq_sel),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.POWER_OFF_FLAG_OUT(flag), .LINE_SYNC(line_sync), .HALTED(halted));

	lrc_host_model host (.clk, .hard_reset_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	always @(posedge clk)
		if (halted === 1'b1)
			halt_cnt++;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		check($sformatf("read %h", a), d, e);
		check($sformatf("rresp %h", a), {30'h0, r}, {30'h0, er});
	endtask

	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [1:0] r;
		host.wr(a, d, r);
		check($sformatf("bresp %h", a), {30'h0, r}, {30'h0, er});
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_defaults();
		check("flag", {31'h0, flag}, 32'h0);
		rchk(ADDR_CMD, 32'h0, RESP_OKAY);
		rchk(ADDR_MODE, 32'h0A000000, RESP_OKAY);
		rchk(ADDR_TIMING, 32'hF0410405, RESP_OKAY);
		rchk(ADDR_IDLE, 32'h00000801, RESP_OKAY);
		rchk(8'h14, 32'h0, RESP_SLVERR);
		wchk(ADDR_STATUS, 32'h3, RESP_SLVERR);
	endtask

	// Display on: stop, init then stop, display-off sequence
	task automatic t_soft_on();
		logic [1:0] sel [3] = '{2'b00, 2'b10, 2'b11};
		int lo [3] = '{1, 130, 260};
		int hi [3] = '{130, 260, 800};
		logic [31:0] tim;
		for (int i = 0; i < 3; i++)
		begin
			{init_sel, seq_sel} <= sel[i];
			wchk(ADDR_TIMING, 32'hF0410406, RESP_OKAY);
			wchk(ADDR_CMD, 32'hFE, RESP_OKAY);
			halt_cnt = 0;
			wchk(ADDR_CMD, 32'hFF, RESP_OKAY);
			host.settle();
			check("halt span", 32'(halt_cnt >= lo[i] && halt_cnt < hi[i]),
				32'h1);
			check("flag", {31'h0, flag}, 32'h1);
			rchk(ADDR_CMD, 32'h0, RESP_OKAY);
			tim = sel[i][1] ? 32'hF0410406 : 32'hF0410405;
			rchk(ADDR_TIMING, tim, RESP_OKAY);
		end
	endtask

	task automatic t_soft_off();
		{init_sel, seq_sel} <= 2'b00;
		wchk(ADDR_TIMING, 32'hF0410406, RESP_OKAY);
		halt_cnt = 0;
		wchk(ADDR_CMD, 32'h01, RESP_OKAY);
		host.settle();
		check("halt span", halt_cnt, 32'h1);
		check("flag", {31'h0, flag}, 32'h0);
		rchk(ADDR_TIMING, 32'hF0410405, RESP_OKAY);
	endtask

	// Line sync period, edge to edge
	task automatic t_line();
		int n;
		n = 0;
		@(posedge clk);
		while (line_sync !== 1'b1)
			@(posedge clk);
		@(posedge clk);
		n = 1;
		while (line_sync !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		check("line period", n, {24'h00_0000, DEF_LINE_CLKS});
	endtask

	// Hard reset with the flag up and settings changed
	task automatic t_hard();
		wchk(ADDR_MODE, 32'h0B000011, RESP_OKAY);
		wchk(ADDR_TIMING, 32'hF0410406, RESP_OKAY);
		wchk(ADDR_CMD, 32'h06, RESP_OKAY);
		{init_sel, seq_sel} <= 2'b11;
		wchk(ADDR_CMD, 32'h07, RESP_OKAY);
		// Pin drops midway through the display-off sequence
		repeat (100) @(posedge clk);
		check("flag high", {31'h0, flag}, 32'h1);
		check("halted high", {31'h0, halted}, 32'h1);
		host.pin(1'b0);
		#1;
		check("flag low", {31'h0, flag}, 32'h0);
		check("halted low", {31'h0, halted}, 32'h0);
		repeat (2) @(posedge clk);
		host.pin(1'b1);
		repeat (3) @(posedge clk);
		rchk(ADDR_MODE, 32'h0A000000, RESP_OKAY);
		rchk(ADDR_TIMING, 32'hF0410405, RESP_OKAY);
	endtask

	// ------------------------------------------------------------
	// Clock, sequence, watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		rst = 1'b1;
		init_sel = 1'b0;
		seq_sel = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_defaults();
		t_line();
		t_soft_on();
		t_soft_off();
		t_hard();
		results();
	end

	// Run needs about 3600 cycles; over five times that before giving up
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results();
	end

endmodule // tb_lrc_reset_ctl
